// ===== plut_pkg.sv
package plut_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [11:0] OFS_SELECT  = 12'h000;
    localparam logic [11:0] OFS_INDEX   = 12'h004;
    localparam logic [11:0] OFS_VALUE   = 12'h008;
    localparam logic [11:0] OFS_ENABLE  = 12'h00c;
    localparam logic [11:0] OFS_STATUS  = 12'h010;

    // ----------------------------------------------------------------
    // Fields and reset values
    // ----------------------------------------------------------------
    localparam int          PIX_W          = 10;
    localparam int          OUT_W          = 8;
    localparam int          TBL_DEPTH      = 1024;
    localparam int          IDX_W          = 10;
    localparam logic [9:0]  TOP_CODE       = 10'h3ff;
    localparam logic [9:0]  LAST_EVEN      = 10'h3fe;
    localparam logic [1:0]  SEL_LUMINANCE  = 2'h0;
    localparam logic [1:0]  SEL_RST        = 2'h0;
    localparam logic [9:0]  IDX_RST        = 10'h000;
    localparam logic        EN_RST         = 1'b0;
    localparam int          FIFO_DEPTH     = 8;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [11:0] paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } plut_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } plut_apb_rsp_s;

endpackage : plut_pkg

// ===== plut_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module plut_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst_n,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } plut_fifo_st_s;

    logic [WIDTH-1:0] mem [DEPTH];
    plut_fifo_st_s    st_r;
    plut_fifo_st_s    st_nxt;
    logic             push;
    logic             pop;

    assign in_ready  = (st_r.cnt != (AW+1)'(DEPTH));
    assign out_valid = (st_r.cnt != '0);
    assign out_data  = mem[st_r.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.wp = (st_r.wp == AW'(DEPTH-1)) ? '0 : st_r.wp + 1'b1;
        end
        if (pop) begin
            st_nxt.rp = (st_r.rp == AW'(DEPTH-1)) ? '0 : st_r.rp + 1'b1;
        end
        st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge clock) begin
        if (push) begin
            mem[st_r.wp] <= in_data;
        end
    end

endmodule : plut_fifo
`default_nettype wire

// ===== plut_top.sv
`timescale 1ns/1ps
`default_nettype none
module plut_top #(
    parameter int FIFO_DEPTH = plut_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  nrst,
    // Register bus
    input  wire plut_pkg::plut_apb_req_s apb_req,
    output plut_pkg::plut_apb_rsp_s    apb_rsp,
    // Sensor sample stream
    input  wire logic                  pix_valid,
    output logic                       pix_ready,
    input  wire logic [9:0]            pix_data,
    // Output pixel stream
    output logic                       out_valid,
    input  wire logic                  out_ready,
    output logic [7:0]                 out_data
);

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic [1:0] rst_sync_r;
    logic       rst_n;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0]  sel;
        logic [9:0]  idx;
        logic        en;
        logic        s1_vld;
        logic [9:0]  s1_pix;
        logic        s1_en;
        logic        s2_vld;
        logic [7:0]  s2_dat;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic [31:0] pix_cnt;
    } plut_st_s;

    plut_st_s   st_r;
    plut_st_s   st_nxt;

    logic [9:0] tbl_lo [plut_pkg::TBL_DEPTH];
    logic [9:0] tbl_hi [plut_pkg::TBL_DEPTH];
    logic [9:0] rd_lo;
    logic [9:0] rd_hi;
    logic [9:0] lo_r;
    logic [9:0] hi_r;
    logic [9:0] wr_r;

    logic       fifo_in_ready;
    logic       apb_setup;
    logic       apb_wr;
    logic       tbl_we;
    logic       adv;
    logic       s1_go;
    logic       s2_go;
    logic [9:0] ev_lo;
    logic [9:0] ev_hi;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] plut_trunc(input logic [9:0] v);
        return v[9:2];
    endfunction : plut_trunc

    function automatic logic [9:0] plut_mid(input logic [9:0] a, input logic [9:0] b);
        logic [10:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[10:1];
    endfunction : plut_mid

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    assign apb_setup = apb_req.psel && !apb_req.penable;
    assign apb_wr    = apb_setup && apb_req.pwrite;
    assign tbl_we    = apb_wr && (apb_req.paddr == plut_pkg::OFS_VALUE)
                       && (st_r.sel == plut_pkg::SEL_LUMINANCE);

    // Two copies so both neighbours are read in one cycle
    always_ff @(posedge clock) begin
        if (tbl_we) begin
            tbl_lo[st_r.idx] <= apb_req.pwdata[9:0];
            tbl_hi[st_r.idx] <= apb_req.pwdata[9:0];
        end
        if (s1_go) begin
            lo_r <= tbl_lo[ev_lo];
            hi_r <= tbl_hi[ev_hi];
        end
    end
    assign rd_lo = lo_r;
    assign rd_hi = hi_r;

    // ----------------------------------------------------------------
    // Pixel pipe
    // ----------------------------------------------------------------
    assign ev_lo = {pix_data[9:1], 1'b0};
    assign ev_hi = (pix_data == plut_pkg::TOP_CODE) ? plut_pkg::LAST_EVEN
                   : ev_lo + 10'h002;
    assign adv       = !st_r.s2_vld || fifo_in_ready;
    assign pix_ready = adv && rst_n;
    assign s1_go     = pix_valid && pix_ready;
    assign s2_go     = st_r.s1_vld && adv;

    always_comb begin
        logic [9:0] mapped;
        mapped = '0;
        st_nxt = st_r;
        // Registers
        st_nxt.pready  = 1'b0;
        st_nxt.pslverr = 1'b0;
        if (apb_setup) begin
            st_nxt.pready = 1'b1;
            st_nxt.prdata = '0;
            unique case (apb_req.paddr)
                plut_pkg::OFS_SELECT: begin
                    st_nxt.prdata[1:0] = st_r.sel;
                    if (apb_req.pwrite) begin
                        // Only the luminance table exists
                        st_nxt.sel = (apb_req.pwdata[1:0] == plut_pkg::SEL_LUMINANCE)
                                     ? apb_req.pwdata[1:0] : st_r.sel;
                        st_nxt.pslverr = (apb_req.pwdata[1:0] != plut_pkg::SEL_LUMINANCE);
                    end
                end
                plut_pkg::OFS_INDEX: begin
                    st_nxt.prdata[9:0] = st_r.idx;
                    if (apb_req.pwrite) begin
                        st_nxt.idx = apb_req.pwdata[9:0];
                    end
                end
                plut_pkg::OFS_VALUE: begin
                    st_nxt.prdata[9:0] = wr_r;
                end
                plut_pkg::OFS_ENABLE: begin
                    st_nxt.prdata[0] = st_r.en;
                    if (apb_req.pwrite) begin
                        st_nxt.en = apb_req.pwdata[0];
                    end
                end
                plut_pkg::OFS_STATUS: begin
                    st_nxt.prdata = st_r.pix_cnt;
                end
                default: begin
                    st_nxt.pslverr = 1'b1;
                end
            endcase
        end
        // Stage 1: table read issued
        if (adv) begin
            st_nxt.s1_vld = s1_go;
        end
        if (s1_go) begin
            st_nxt.s1_pix = pix_data;
            st_nxt.s1_en  = st_r.en;
        end
        // Stage 2: map and truncate
        if (st_r.s1_en) begin
            if (st_r.s1_pix[0] && st_r.s1_pix != plut_pkg::TOP_CODE) begin
                mapped = plut_mid(rd_lo, rd_hi);
            end else begin
                mapped = rd_lo;
            end
        end else begin
            mapped = st_r.s1_pix;
        end
        if (adv) begin
            st_nxt.s2_vld = s2_go;
            if (s2_go) begin
                st_nxt.s2_dat  = plut_trunc(mapped);
                st_nxt.pix_cnt = st_r.pix_cnt + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r     <= '0;
            st_r.sel <= plut_pkg::SEL_RST;
            st_r.idx <= plut_pkg::IDX_RST;
            st_r.en  <= plut_pkg::EN_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Last value written, for readback
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_r <= '0;
        end else if (tbl_we) begin
            wr_r <= apb_req.pwdata[9:0];
        end
    end

    assign apb_rsp.prdata  = st_r.prdata;
    assign apb_rsp.pready  = st_r.pready;
    assign apb_rsp.pslverr = st_r.pslverr;

    // ----------------------------------------------------------------
    // Output buffer
    // ----------------------------------------------------------------
    plut_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .rst_n     (rst_n),
        .in_valid  (st_r.s2_vld),
        .in_ready  (fifo_in_ready),
        .in_data   (st_r.s2_dat),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (out_data)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_bypass_trunc: assert property (
        s2_go && !st_r.s1_en |=> st_r.s2_dat == $past(st_r.s1_pix[9:2]))
        else $error("bypass output not truncated sample");
    a_even_direct: assert property (
        s2_go && st_r.s1_en && !st_r.s1_pix[0] |=> st_r.s2_dat == $past(rd_lo[9:2]))
        else $error("even sample not mapped directly");
    a_odd_interp: assert property (
        s2_go && st_r.s1_en && st_r.s1_pix[0] && st_r.s1_pix != 10'h3ff
        |=> st_r.s2_dat == $past((11'(rd_lo) + 11'(rd_hi)) >> 3))
        else $error("odd sample not interpolated");
    a_top_hold: assert property (
        s2_go && st_r.s1_en && st_r.s1_pix == 10'h3ff |=> st_r.s2_dat == $past(rd_lo[9:2]))
        else $error("top code not using last even entry");
    a_top_addr: assert property (
        s1_go && pix_data == 10'h3ff |-> ev_lo == 10'h3fe && ev_hi == 10'h3fe)
        else $error("top code reads wrong entries");
    a_idx_write: assert property (
        apb_wr && apb_req.paddr == 12'h004 |=> st_r.idx == $past(apb_req.pwdata[9:0]))
        else $error("index not updated");
    a_val_store: assert property (
        tbl_we |=> tbl_lo[$past(st_r.idx)] == $past(apb_req.pwdata[9:0]))
        else $error("value not stored at index");
    a_en_steer: assert property (
        s1_go |=> st_r.s1_en == $past(st_r.en))
        else $error("enable not sampled with pixel");
    a_sel_only: assert property (
        st_r.sel == 2'h0)
        else $error("selector left luminance table");
    a_apb_ready: assert property (
        apb_setup |=> apb_rsp.pready ##1 !apb_rsp.pready)
        else $error("bus answer timing wrong");
    a_sel_refuse: assert property (
        apb_wr && apb_req.paddr == 12'h000 && apb_req.pwdata[1:0] != 2'h0
        |=> apb_rsp.pslverr)
        else $error("bad table select not refused");
    a_en_write: assert property (
        apb_wr && apb_req.paddr == 12'h00c |=> st_r.en == $past(apb_req.pwdata[0]))
        else $error("enable not updated");
    a_hi_addr: assert property (
        s1_go && pix_data[0] && pix_data != 10'h3ff |-> ev_hi == pix_data + 10'h001)
        else $error("odd sample reads wrong upper entry");
    a_stall_hold: assert property (
        st_r.s2_vld && !fifo_in_ready |=> st_r.s2_vld && $stable(st_r.s2_dat))
        else $error("stalled result not held");
    a_cnt_step: assert property (
        s2_go |=> st_r.pix_cnt == $past(st_r.pix_cnt) + 32'h0000_0001)
        else $error("pixel count not stepped");

    c_bypass_px: cover property (s2_go && !st_r.s1_en);
    c_odd_px:    cover property (s2_go && st_r.s1_en && st_r.s1_pix[0]);
    c_top_px:    cover property (s2_go && st_r.s1_en && st_r.s1_pix == 10'h3ff);
    c_fifo_full: cover property (!fifo_in_ready ##1 out_ready);
    c_sel_err:   cover property (apb_rsp.pslverr);

endmodule : plut_top
`default_nettype wire

// ===== plut_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module plut_src_model (
    // Clock
    input  wire logic       clock,
    // Pacing
    input  wire logic       slow,
    // Sample stream
    output logic            pix_valid,
    input  wire logic       pix_ready,
    output logic [9:0]      pix_data
);
    logic [9:0] q[$];
    logic       gap_r;

    function automatic void push(input logic [9:0] v);
        q.push_back(v);
    endfunction : push

    initial begin
        pix_valid = 1'b0;
        pix_data  = 10'h000;
        gap_r     = 1'b0;
    end

    // ----------------------------------------------------------------
    // Sample held until taken; idle data toggles each cycle
    // ----------------------------------------------------------------
    always @(posedge clock) begin
        if (!pix_valid || pix_ready) begin
            gap_r <= slow && !gap_r;
            if (q.size() > 0 && !(slow && !gap_r)) begin
                pix_valid <= 1'b1;
                pix_data  <= q.pop_front();
            end else begin
                pix_valid <= 1'b0;
                pix_data  <= ~pix_data;
            end
        end
    end
endmodule : plut_src_model
`default_nettype wire

// ===== pixel_lut_interpolator_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pixel_lut_interpolator_tb_top;
    logic                    clock;
    logic                    nrst;
    plut_pkg::plut_apb_req_s apb_req;
    plut_pkg::plut_apb_rsp_s apb_rsp;
    logic                    pix_valid;
    logic                    pix_ready;
    logic [9:0]              pix_data;
    logic                    out_valid;
    logic                    out_ready = 1'b0;
    logic [7:0]              out_data;
    logic                    slow;
    logic [1:0]              sink_mode;
    logic [1:0]              cyc = 2'h0;
    logic [9:0]              tbl[1024];
    logic [9:0]              sq[$];
    logic [7:0]              got[$];
    int                      n_errors;
    int                      n_compared;
    int                      n_out;

    plut_top dut_u (
        .clock(clock), .nrst(nrst), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_data(pix_data),
        .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data)
    );

    plut_src_model src_u (
        .clock(clock), .slow(slow), .pix_valid(pix_valid),
        .pix_ready(pix_ready), .pix_data(pix_data)
    );

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // ----------------------------------------------------------------
    // Sink pacing and capture
    // ----------------------------------------------------------------
    always @(posedge clock) begin
        cyc       <= cyc + 2'h1;
        out_ready <= (sink_mode == 2'h0) || (sink_mode == 2'h1 && cyc == 2'h0);
        if (out_valid && out_ready) got.push_back(out_data);
    end

    task automatic give_verdict();
        if (n_errors == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    // ----------------------------------------------------------------
    // APB master
    // ----------------------------------------------------------------
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                       input logic [31:0] ed, input logic ee);
        logic [31:0] rd;
        logic        er;
        @(posedge clock);
        apb_req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
        @(posedge clock);
        apb_req.penable <= 1'b1;
        do @(posedge clock); while (apb_rsp.pready !== 1'b1);
        rd = apb_rsp.prdata;
        er = apb_rsp.pslverr;
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
        check({31'h0, er}, {31'h0, ee});
        if (!w) check(rd, ed);
    endtask : apb

    function automatic logic [7:0] exp_pix(input logic [9:0] v, input logic en);
        logic [10:0] m;
        if (!en) return v[9:2];
        if (v == 10'h3ff) m = {1'b0, tbl[1022]};
        else if (!v[0]) m = {1'b0, tbl[v]};
        else m = ({1'b0, tbl[v - 1]} + {1'b0, tbl[v + 1]}) >> 1;
        return m[9:2];
    endfunction : exp_pix

    task automatic send_check(input logic en);
        int n;
        int t;
        n = sq.size();
        got.delete();
        foreach (sq[i]) src_u.push(sq[i]);
        t = 0;
        while (got.size() < n && t < 3000) begin
            @(posedge clock);
            t++;
        end
        check(got.size(), n);
        foreach (sq[i]) if (i < got.size()) check(got[i], exp_pix(sq[i], en));
        n_out += n;
        sq.delete();
    endtask : send_check

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        apb(plut_pkg::OFS_SELECT, 1'b0, 0, 32'h0, 1'b0);
        apb(plut_pkg::OFS_INDEX, 1'b0, 0, 32'h0, 1'b0);
        apb(plut_pkg::OFS_ENABLE, 1'b0, 0, 32'h0, 1'b0);
        apb(plut_pkg::OFS_STATUS, 1'b0, 0, 32'h0, 1'b0);
        apb(12'h014, 1'b0, 0, 32'h0, 1'b1);
        apb(plut_pkg::OFS_SELECT, 1'b1, 32'h1, 0, 1'b1);
        apb(plut_pkg::OFS_SELECT, 1'b0, 0, 32'h0, 1'b0);
        apb(plut_pkg::OFS_SELECT, 1'b1, 32'h0, 0, 1'b0);
    endtask : t_regs

    task automatic t_fill_pass();
        sink_mode <= 2'h2;
        for (int i = 0; i < 16; i++) src_u.push(10'(i * 67 + 3));
        repeat (40) @(posedge clock);
        check({31'h0, pix_ready}, 32'h0);
        check({31'h0, out_valid}, 32'h1);
        sink_mode <= 2'h0;
        for (int i = 0; i < 16; i++) sq.push_back(10'(i * 67 + 3));
        sq.delete();
        for (int i = 0; i < 16; i++) sq.push_front(10'(i * 67 + 3));
        sq.reverse();
        send_wait_only();
    endtask : t_fill_pass

    task automatic send_wait_only();
        int t;
        t = 0;
        while (got.size() < sq.size() && t < 3000) begin
            @(posedge clock);
            t++;
        end
        foreach (sq[i]) if (i < got.size()) check(got[i], exp_pix(sq[i], 1'b0));
        check(got.size(), sq.size());
        n_out += sq.size();
        sq.delete();
    endtask : send_wait_only

    task automatic t_table();
        for (int i = 0; i < 1024; i++) begin
            tbl[i] = i[0] ? 10'h155 : 10'((i * 5 + (i >> 2)) & 32'h3ff);
            apb(plut_pkg::OFS_INDEX, 1'b1, i, 0, 1'b0);
            apb(plut_pkg::OFS_VALUE, 1'b1, tbl[i], 0, 1'b0);
        end
        apb(plut_pkg::OFS_INDEX, 1'b0, 0, 32'h3ff, 1'b0);
        apb(plut_pkg::OFS_VALUE, 1'b0, 0, 32'h155, 1'b0);
    endtask : t_table

    task automatic t_mapped();
        apb(plut_pkg::OFS_ENABLE, 1'b1, 32'h1, 0, 1'b0);
        sink_mode <= 2'h1;
        slow      <= 1'b1;
        sq        = '{0, 1, 2, 3, 5, 6, 511, 512, 1021, 1022, 1023, 7};
        send_check(1'b1);
        slow <= 1'b0;
        sq   = '{1023, 0, 1, 1022, 999, 4};
        send_check(1'b1);
    endtask : t_mapped

    task automatic t_disable();
        apb(plut_pkg::OFS_ENABLE, 1'b1, 32'h0, 0, 1'b0);
        sink_mode <= 2'h0;
        sq        = '{1, 3, 1023, 5, 512};
        send_check(1'b0);
        apb(plut_pkg::OFS_STATUS, 1'b0, 0, n_out, 1'b0);
    endtask : t_disable

    initial begin
        nrst       = 1'b0;
        apb_req    = '0;
        slow       = 1'b0;
        sink_mode  = 2'h0;
        n_errors   = 0;
        n_compared = 0;
        n_out      = 0;
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        repeat (4) @(posedge clock);
        t_regs();
        t_fill_pass();
        t_table();
        t_mapped();
        t_disable();
        give_verdict();
    end

    initial begin
        repeat (60000) @(posedge clock);
        n_errors++;
        give_verdict();
    end
endmodule : pixel_lut_interpolator_tb_top
`default_nettype wire
